// [src/ddc_top.sv]
// serial command unit of a dual voltage-output converter, with APB view
`default_nettype none

module ddc_top (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial link pins
	input wire logic frame_sync_n,
	input wire logic serial_clk,
	input wire logic serial_din,
	// hardware control pins
	input wire logic load_converter_n,
	input wire logic clear_outputs_n,
	// converter side
	output logic [15:0] dac_code_a,
	output logic [15:0] dac_code_b,
	output logic [1:0] power_mode_a,
	output logic [1:0] power_mode_b,
	output logic ref_enable
);

	// ********************************************************
	// pin synchronisers
	// ********************************************************
	logic [4:0] pins_s;
	logic sync_s;
	logic sclk_s;
	logic din_s;
	logic load_s;
	logic clear_s;

	ddc_sync #(.W(5), .INIT(5'h1F)) u_sync (
		.clock(clock),
		.arst_n(arst_n),
		.d({frame_sync_n, serial_clk, serial_din, load_converter_n,
			clear_outputs_n}),
		.q(pins_s)
	);

	assign {sync_s, sclk_s, din_s, load_s, clear_s} = pins_s;

	// ********************************************************
	// frame receiver
	// ********************************************************
	ddc_pkg::ddc_state_t state_reg;
	ddc_pkg::ddc_state_t state_next;
	logic [4:0] cnt_reg;
	logic [4:0] cnt_next;
	logic [23:0] shift_reg;
	logic [23:0] shift_next;
	logic [23:0] frame_reg;
	logic [23:0] frame_next;
	logic exec_reg;
	logic exec_next;
	logic abort_reg;
	logic abort_next;
	logic sync_prev_reg;
	logic sclk_prev_reg;
	logic sync_fall;
	logic sclk_fall;

	assign sync_fall = sync_prev_reg && !sync_s;
	assign sclk_fall = sclk_prev_reg && !sclk_s;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		frame_next = frame_reg;
		exec_next = 1'b0;
		abort_next = 1'b0;
		case (state_reg)
			ddc_pkg::ST_IDLE: begin
				if (sync_fall) begin
					state_next = ddc_pkg::ST_SHIFT;
					cnt_next = '0;
					shift_next = '0;
				end
			end
			ddc_pkg::ST_SHIFT: begin
				if (sync_s) begin
					state_next = ddc_pkg::ST_IDLE;
					cnt_next = '0;
					shift_next = '0;
					abort_next = 1'b1;
				end else if (sclk_fall) begin
					// msb first: first bit ends in bit 23
					shift_next = {shift_reg[22:0], din_s};
					cnt_next = cnt_reg + 5'h01;
					if (cnt_reg == ddc_pkg::LAST_BIT) begin
						exec_next = 1'b1;
						frame_next = {shift_reg[22:0], din_s};
						state_next = ddc_pkg::ST_HOLD;
					end
				end
			end
			ddc_pkg::ST_HOLD: begin
				// extra clocks after the 24th are ignored until release
				if (sync_s) begin
					state_next = ddc_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = ddc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ddc_pkg::ST_IDLE;
			cnt_reg <= '0;
			shift_reg <= '0;
			frame_reg <= '0;
			exec_reg <= 1'b0;
			abort_reg <= 1'b0;
			sync_prev_reg <= 1'b1;
			sclk_prev_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			frame_reg <= frame_next;
			exec_reg <= exec_next;
			abort_reg <= abort_next;
			sync_prev_reg <= sync_s;
			sclk_prev_reg <= sclk_s;
		end
	end

	// ********************************************************
	// command decode
	// ********************************************************
	logic [1:0] res_reg;
	logic [2:0] cmd;
	logic [2:0] addr;
	logic [15:0] code;
	logic [15:0] res_mask;
	logic [1:0] sel;
	logic addr_ok;
	logic is_wr;
	logic is_upd;
	logic soft_zero;
	logic soft_full;

	always_comb begin
		case (res_reg)
			ddc_pkg::RES_14: res_mask = ddc_pkg::MASK_14;
			ddc_pkg::RES_12: res_mask = ddc_pkg::MASK_12;
			default: res_mask = ddc_pkg::MASK_16;
		endcase
	end

	// field split of the completed frame
	assign cmd = frame_reg[ddc_pkg::CMD_HI:ddc_pkg::CMD_LO];
	assign addr = frame_reg[ddc_pkg::ADDR_HI:ddc_pkg::ADDR_LO];
	assign code = frame_reg[ddc_pkg::DATA_HI:0] & res_mask;
	assign sel[0] = (addr == ddc_pkg::ADDR_A) || (addr == ddc_pkg::ADDR_ALL);
	assign sel[1] = (addr == ddc_pkg::ADDR_B) || (addr == ddc_pkg::ADDR_ALL);
	assign addr_ok = |sel;
	assign is_wr = (cmd == ddc_pkg::CMD_WR_IN) ||
		(cmd == ddc_pkg::CMD_WR_UPD_ALL) || (cmd == ddc_pkg::CMD_WR_UPD);
	assign is_upd = (cmd == ddc_pkg::CMD_UPD) || (cmd == ddc_pkg::CMD_WR_UPD);
	assign soft_zero = exec_reg && (cmd == ddc_pkg::CMD_RESET);
	assign soft_full = soft_zero && frame_reg[ddc_pkg::RST_DEPTH_BIT];

	// ********************************************************
	// power-on interval, mask, reference, counters
	// ********************************************************
	logic [9:0] por_cnt_reg;
	logic [9:0] por_cnt_next;
	logic por_done_reg;
	logic por_done_next;
	logic [1:0] mask_reg;
	logic [1:0] mask_next;
	logic ref_reg;
	logic ref_next;
	logic [15:0] good_reg;
	logic [15:0] good_next;
	logic [15:0] bad_reg;
	logic [15:0] bad_next;
	logic load_low;
	logic clear_zero;

	// pins count only after the power-on interval
	assign load_low = por_done_reg && !load_s;
	assign clear_zero = por_done_reg && !clear_s;

	always_comb begin
		por_cnt_next = por_cnt_reg;
		por_done_next = por_done_reg;
		mask_next = mask_reg;
		ref_next = ref_reg;
		good_next = good_reg;
		bad_next = bad_reg;
		if (!por_done_reg) begin
			por_cnt_next = por_cnt_reg + 10'h001;
			por_done_next = (por_cnt_reg == ddc_pkg::POR_LAST);
		end
		if (exec_reg && (cmd == ddc_pkg::CMD_MASK)) begin
			mask_next = frame_reg[ddc_pkg::SEL_B_BIT:ddc_pkg::SEL_A_BIT];
		end
		if (exec_reg && (cmd == ddc_pkg::CMD_REF)) begin
			ref_next = frame_reg[ddc_pkg::REF_BIT];
		end
		if (soft_full) begin
			mask_next = '0;
			ref_next = 1'b0;
		end
		if (exec_reg) begin
			good_next = good_reg + 16'h0001;
		end
		if (abort_reg) begin
			bad_next = bad_reg + 16'h0001;
		end
	end

	// reference starts off
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			por_cnt_reg <= '0;
			por_done_reg <= 1'b0;
			mask_reg <= '0;
			ref_reg <= 1'b0;
			good_reg <= '0;
			bad_reg <= '0;
		end else begin
			por_cnt_reg <= por_cnt_next;
			por_done_reg <= por_done_next;
			mask_reg <= mask_next;
			ref_reg <= ref_next;
			good_reg <= good_next;
			bad_reg <= bad_next;
		end
	end

	// ********************************************************
	// channels
	// ********************************************************
	logic [15:0] in_q [0:1];
	logic [15:0] conv_q [0:1];
	logic [1:0] mode_q [0:1];

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_chan
			logic wr_in;
			logic upd_now;
			logic set_mode;
			// reserved address: no channel selected
			assign wr_in = exec_reg && is_wr && sel[gi];
			assign upd_now = exec_reg && addr_ok &&
				((is_upd && sel[gi]) || (cmd == ddc_pkg::CMD_WR_UPD_ALL));
			assign set_mode = exec_reg && (cmd == ddc_pkg::CMD_POWER) &&
				frame_reg[gi];
			ddc_chan u_chan (
				.clock(clock),
				.arst_n(arst_n),
				.wr_in(wr_in),
				.upd_now(upd_now),
				.data(code),
				.frame_end(exec_reg),
				.soft_zero(soft_zero),
				.soft_full(soft_full),
				.set_mode(set_mode),
				.mode_val(frame_reg[ddc_pkg::PD_HI_BIT:ddc_pkg::PD_LO_BIT]),
				.mask_bit(mask_reg[gi]),
				.load_low(load_low),
				.clear_zero(clear_zero),
				.in_q(in_q[gi]),
				.conv_q(conv_q[gi]),
				.mode_q(mode_q[gi])
			);
		end
	endgenerate

	assign dac_code_a = conv_q[0];
	assign dac_code_b = conv_q[1];
	assign power_mode_a = mode_q[0];
	assign power_mode_b = mode_q[1];
	assign ref_enable = ref_reg;

	// ********************************************************
	// apb slave: one wait state, then pready for one cycle
	// ********************************************************
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic [1:0] res_next;

	always_comb begin
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		prdata_next = prdata_reg;
		res_next = res_reg;
		if (psel && penable && !pready_reg) begin
			pready_next = 1'b1;
			case (paddr)
				ddc_pkg::OFS_CTRL: prdata_next = {30'h0, res_reg};
				ddc_pkg::OFS_STATUS: prdata_next = {21'h0, por_done_reg,
					ref_reg, mask_reg, mode_q[1], mode_q[0], state_reg};
				ddc_pkg::OFS_CODE_A: prdata_next = {in_q[0], conv_q[0]};
				ddc_pkg::OFS_CODE_B: prdata_next = {in_q[1], conv_q[1]};
				ddc_pkg::OFS_FRAMES: prdata_next = {bad_reg, good_reg};
				default: begin
					prdata_next = '0;
					pslverr_next = 1'b1;
				end
			endcase
		end
		if (psel && penable && pready_reg && pwrite &&
			(paddr == ddc_pkg::OFS_CTRL)) begin
			res_next = pwdata[1:0];
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
			res_reg <= ddc_pkg::CTRL_RESET;
		end else begin
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
			res_reg <= res_next;
		end
	end

	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata = prdata_reg;

	// ********************************************************
	// assertions
	// ********************************************************
	sequence s_last_edge;
		state_reg == ddc_pkg::ST_SHIFT && !sync_s && sclk_fall &&
			cnt_reg == ddc_pkg::LAST_BIT;
	endsequence

	sequence s_one_exec;
		exec_reg ##1 !exec_reg;
	endsequence

	a_start_on_fall: assert property (@(posedge clock) disable iff (!arst_n)
		state_reg == ddc_pkg::ST_IDLE && !sync_fall |=>
			state_reg == ddc_pkg::ST_IDLE)
		else $error("frame started without a select fall");

	a_shift_msb: assert property (@(posedge clock) disable iff (!arst_n)
		state_reg == ddc_pkg::ST_SHIFT && !sync_s && sclk_fall |=>
			shift_reg == {$past(shift_reg[22:0]), $past(din_s)})
		else $error("shift register did not take the serial bit");

	a_exec_last: assert property (@(posedge clock) disable iff (!arst_n)
		s_last_edge |=> s_one_exec)
		else $error("command not run once on the 24th edge");

	a_abort_clear: assert property (@(posedge clock) disable iff (!arst_n)
		state_reg == ddc_pkg::ST_SHIFT && sync_s |=>
			shift_reg == '0 && !exec_reg && $stable(dac_code_a) &&
			$stable(power_mode_b))
		else $error("aborted frame left state behind");

	a_por_ignore: assert property (@(posedge clock) disable iff (!arst_n)
		!por_done_reg && !exec_reg |=> $stable(dac_code_a) &&
			$stable(dac_code_b))
		else $error("pin acted during power-on interval");

	a_reset_zero: assert property (@(posedge clock) disable iff (!arst_n)
		soft_zero |=> dac_code_a == '0 && dac_code_b == '0 &&
			in_q[0] == '0 && in_q[1] == '0)
		else $error("software reset left a code");

	a_pd_select: assert property (@(posedge clock) disable iff (!arst_n)
		exec_reg && cmd == ddc_pkg::CMD_POWER |=>
			power_mode_a == ($past(frame_reg[0]) ?
				$past(frame_reg[5:4]) : $past(power_mode_a)))
		else $error("power mode wrong on channel A");

	a_mask_load: assert property (@(posedge clock) disable iff (!arst_n)
		exec_reg && cmd == ddc_pkg::CMD_MASK |=>
			mask_reg == $past(frame_reg[1:0]))
		else $error("load mask not loaded");

	a_ref_set: assert property (@(posedge clock) disable iff (!arst_n)
		exec_reg && cmd == ddc_pkg::CMD_REF |=>
			ref_enable == $past(frame_reg[0]))
		else $error("reference enable not set from bit 0");

	a_reserved_addr: assert property (@(posedge clock) disable iff (!arst_n)
		exec_reg && !addr_ok && cmd[2] == 1'b0 |=>
			$stable(in_q[0]) && $stable(in_q[1]))
		else $error("reserved address changed a channel");

endmodule : ddc_top

`default_nettype wire

// [src/ddc_pkg.sv]
// constants and types shared by the dual converter serial command unit
`default_nettype none

package ddc_pkg;

	// ********************************************************
	// serial frame layout
	// ********************************************************
	localparam int FRAME_BITS = 24;
	localparam logic [4:0] LAST_BIT = 5'h17;
	localparam int CMD_HI = 21;
	localparam int CMD_LO = 19;
	localparam int ADDR_HI = 18;
	localparam int ADDR_LO = 16;
	localparam int DATA_HI = 15;
	localparam int PD_HI_BIT = 5;
	localparam int PD_LO_BIT = 4;
	localparam int SEL_B_BIT = 1;
	localparam int SEL_A_BIT = 0;
	localparam int RST_DEPTH_BIT = 0;
	localparam int REF_BIT = 0;

	// ********************************************************
	// commands and channel codes
	// ********************************************************
	localparam logic [2:0] CMD_WR_IN = 3'h0;
	localparam logic [2:0] CMD_UPD = 3'h1;
	localparam logic [2:0] CMD_WR_UPD_ALL = 3'h2;
	localparam logic [2:0] CMD_WR_UPD = 3'h3;
	localparam logic [2:0] CMD_POWER = 3'h4;
	localparam logic [2:0] CMD_RESET = 3'h5;
	localparam logic [2:0] CMD_MASK = 3'h6;
	localparam logic [2:0] CMD_REF = 3'h7;
	localparam logic [2:0] ADDR_A = 3'h0;
	localparam logic [2:0] ADDR_B = 3'h1;
	localparam logic [2:0] ADDR_ALL = 3'h7;
	localparam logic [1:0] MODE_NORMAL = 2'h0;

	// ********************************************************
	// resolution select and code masks
	// ********************************************************
	localparam logic [1:0] RES_16 = 2'h0;
	localparam logic [1:0] RES_14 = 2'h1;
	localparam logic [1:0] RES_12 = 2'h2;
	localparam logic [15:0] MASK_16 = 16'hFFFF;
	localparam logic [15:0] MASK_14 = 16'hFFFC;
	localparam logic [15:0] MASK_12 = 16'hFFF0;

	// ********************************************************
	// timing
	// ********************************************************
	localparam int CLK_MHZ = 250;
	localparam int POR_TIME_NS = 1000;
	localparam int POR_CYCLES = (POR_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam logic [9:0] POR_LAST = 10'(POR_CYCLES - 1);

	// ********************************************************
	// register map (byte addresses) and reset values
	// ********************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CODE_A = 8'h08;
	localparam logic [7:0] OFS_CODE_B = 8'h0C;
	localparam logic [7:0] OFS_FRAMES = 8'h10;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// ********************************************************
	// frame state machine
	// ********************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SHIFT = 3'b010,
		ST_HOLD = 3'b100
	} ddc_state_t;

endpackage : ddc_pkg

`default_nettype wire

// [src/ddc_sync.sv]
// two-flop synchroniser for pins entering the clock domain
`default_nettype none

module ddc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// pins in, synchronised levels out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg <= INIT;
			q_reg <= INIT;
		end else begin
			meta_reg <= d;
			q_reg <= meta_reg;
		end
	end

	assign q = q_reg;

endmodule : ddc_sync

`default_nettype wire

// [src/ddc_chan.sv]
// one converter channel: input register, converter register, output mode
`default_nettype none

module ddc_chan (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// frame actions
	input wire logic wr_in,
	input wire logic upd_now,
	input wire logic [15:0] data,
	input wire logic frame_end,
	input wire logic soft_zero,
	input wire logic soft_full,
	input wire logic set_mode,
	input wire logic [1:0] mode_val,
	// load control
	input wire logic mask_bit,
	input wire logic load_low,
	input wire logic clear_zero,
	// state
	output logic [15:0] in_q,
	output logic [15:0] conv_q,
	output logic [1:0] mode_q
);

	logic [15:0] in_reg;
	logic [15:0] in_next;
	logic [15:0] conv_reg;
	logic [15:0] conv_next;
	logic [1:0] mode_reg;
	logic [1:0] mode_next;

	always_comb begin
		in_next = in_reg;
		conv_next = conv_reg;
		mode_next = mode_reg;
		if (wr_in) begin
			in_next = data;
		end
		// entering power-down touches only the mode
		if (set_mode) begin
			mode_next = mode_val;
		end
		if (upd_now || (frame_end && mask_bit)) begin
			conv_next = in_next;
		end else if (load_low && !mask_bit) begin
			// transparent while low; also the resume value
			conv_next = in_reg;
		end
		if (clear_zero) begin
			conv_next = '0;
		end
		if (soft_zero) begin
			in_next = '0;
			conv_next = '0;
		end
		if (soft_full) begin
			mode_next = ddc_pkg::MODE_NORMAL;
		end
	end

	// zero code from reset until a frame says otherwise
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			in_reg <= '0;
			conv_reg <= '0;
			mode_reg <= ddc_pkg::MODE_NORMAL;
		end else begin
			in_reg <= in_next;
			conv_reg <= conv_next;
			mode_reg <= mode_next;
		end
	end

	assign in_q = in_reg;
	assign conv_q = conv_reg;
	assign mode_q = mode_reg;

endmodule : ddc_chan

`default_nettype wire

// [dv/ddc_host.sv]
// serial host model that drives frames into the converter unit
`default_nettype none

module ddc_host (
	// serial pins toward the device
	output var logic frame_sync_n,
	output var logic serial_clk,
	output var logic serial_din
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		frame_sync_n = 1'b1;
		serial_clk = 1'b1;
		serial_din = 1'b0;
	end

	// ********************************************************
	// frame driver; n below 24 aborts the frame early
	// ********************************************************
	task automatic send(input logic [23:0] w, input int n);
		// step off the bench clock edges; select goes high just before
		// the frame and stays high long enough for its fall to be seen
		#1 frame_sync_n = 1'b1;
		#24 frame_sync_n = 1'b0;
		for (int i = 23; i > 23 - n; i--) begin
			serial_din = w[i];
			#24 serial_clk = 1'b0;
			#24 serial_clk = 1'b1;
		end
		// line released: no pull, so show the inverse, not a stale bit
		serial_din = ~serial_din;
		// a complete frame leaves select idling low to save power
		if (n < 24) begin
			frame_sync_n = 1'b1;
		end
		#24;
	endtask : send
endmodule : ddc_host

`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench of the converter serial command unit
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic clock, arst_n, psel, penable, pwrite, pready, pslverr, ref_enable;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] dac_code_a, dac_code_b;
	logic [1:0] power_mode_a, power_mode_b;
	logic fs_n, sclk, din, ld_n, clear_n, er;
	int num_errors = 0;
	int total_checks = 0;

	ddc_top uut (.clock(clock), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .frame_sync_n(fs_n), .serial_clk(sclk),
		.serial_din(din), .load_converter_n(ld_n),
		.clear_outputs_n(clear_n), .dac_code_a(dac_code_a),
		.dac_code_b(dac_code_b), .power_mode_a(power_mode_a),
		.power_mode_b(power_mode_b), .ref_enable(ref_enable));
	ddc_host host (.frame_sync_n(fs_n), .serial_clk(sclk),
		.serial_din(din));

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// ********************************************************
	// helpers
	// ********************************************************
	task conclude;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			num_errors++;
			conclude();
		end
	endtask : apb

	task frm(input logic [2:0] c, input logic [2:0] a, input logic [15:0] d,
		input int n);
		host.send({2'h0, c, a, d}, n);
		repeat (10) @(posedge clock);
	endtask : frm

	// ********************************************************
	// main sequence
	// ********************************************************
	initial begin
		arst_n = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ld_n = 1'b1;
		clear_n = 1'b1;
		repeat (4) @(posedge clock);
		arst_n <= 1'b1;
		// pins pulled low inside the power-on interval must do nothing
		ld_n <= 1'b0;
		clear_n <= 1'b0;
		apb(1'b0, 8'h04, 32'h0);
		chk("por_busy", 32'h0, rd & 32'h400);
		chk("por_code", 32'h0, {dac_code_b, dac_code_a});
		ld_n <= 1'b1;
		clear_n <= 1'b1;
		repeat (260) @(posedge clock);
		chk("code_a", 32'h0, {16'h0, dac_code_a});
		chk("ref", 32'h0, {31'h0, ref_enable});
		apb(1'b0, 8'h20, 32'h0);
		chk("slverr", 32'h1, {31'h0, er});
		frm(3'h0, 3'h0, 16'h1234, 24);
		chk("hold_a", 32'h0, {16'h0, dac_code_a});
		apb(1'b0, 8'h08, 32'h0);
		chk("in_a", 32'h12340000, rd);
		frm(3'h1, 3'h0, 16'h0, 24);
		chk("upd_a", 32'h1234, {16'h0, dac_code_a});
		frm(3'h3, 3'h1, 16'hBEEF, 24);
		chk("wu_b", 32'hBEEF, {16'h0, dac_code_b});
		frm(3'h3, 3'h2, 16'h1111, 24);
		chk("rsv_b", 32'hBEEF, {16'h0, dac_code_b});
		frm(3'h3, 3'h0, 16'h5555, 12);
		chk("abort_a", 32'h1234, {16'h0, dac_code_a});
		frm(3'h2, 3'h0, 16'h00AA, 24);
		chk("all_a", 32'h00AA, {16'h0, dac_code_a});
		chk("all_b", 32'hBEEF, {16'h0, dac_code_b});
		frm(3'h4, 3'h7, 16'h0031, 24);
		chk("pd", 32'h3, {28'h0, power_mode_b, power_mode_a});
		frm(3'h6, 3'h0, 16'h0002, 24);
		frm(3'h0, 3'h1, 16'h7777, 24);
		chk("mask_b", 32'h7777, {16'h0, dac_code_b});
		frm(3'h7, 3'h0, 16'h0001, 24);
		chk("ref_on", 32'h1, {31'h0, ref_enable});
		frm(3'h0, 3'h0, 16'h4321, 24);
		chk("pd_keep", 32'h00AA, {16'h0, dac_code_a});
		ld_n <= 1'b0;
		repeat (10) @(posedge clock);
		chk("ld_a", 32'h4321, {16'h0, dac_code_a});
		frm(3'h4, 3'h0, 16'h0001, 24);
		chk("pu_a", 32'h4321, {14'h0, power_mode_a, dac_code_a});
		apb(1'b1, 8'h00, 32'h2);
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl", 32'h2, rd);
		frm(3'h3, 3'h0, 16'hABCD, 24);
		chk("res12", 32'hABC0, {16'h0, dac_code_a});
		clear_n <= 1'b0;
		repeat (10) @(posedge clock);
		chk("clear_a", 32'h0, {16'h0, dac_code_a});
		clear_n <= 1'b1;
		repeat (10) @(posedge clock);
		chk("clear_off", 32'hABC0, {16'h0, dac_code_a});
		frm(3'h5, 3'h0, 16'h0000, 24);
		chk("sr0", 32'h10000, {15'h0, ref_enable, dac_code_a});
		chk("sr0_b", 32'h0, {16'h0, dac_code_b});
		frm(3'h5, 3'h0, 16'h0001, 24);
		apb(1'b0, 8'h04, 32'h0);
		chk("sr1", 32'h400, rd & 32'h7F8);
		conclude();
	end

	initial begin
		#200000;
		num_errors++;
		conclude();
	end
endmodule : tb_top

`default_nettype wire
